// ### rtl/xlat_attr_pkg.sv
// Shared constants and carriers for translation attribute resolution
package xlat_attr_pkg;
    localparam int PA_W = 48;
    localparam int VA_W = 48;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_WALK_ATTR = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_FAULT_LO  = 8'h0c;
    localparam logic [7:0] OFS_FAULT_HI  = 8'h10;
    localparam logic [7:0] OFS_ASYNC     = 8'h14;
    localparam logic [7:0] OFS_GEOMETRY  = 8'h18;
    // Control field positions
    localparam int CTRL_S1_AF  = 0;
    localparam int CTRL_S1_DS  = 1;
    localparam int CTRL_S2_AF  = 2;
    localparam int CTRL_S2_DS  = 3;
    localparam int CTRL_IC_EN  = 4;
    localparam int CTRL_DC_EN  = 5;
    localparam int CTRL_S1_PB  = 6;
    localparam int CTRL_S2_PB  = 8;
    localparam int CTRL_W      = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
    localparam logic [5:0]  WALK_RESET = 6'h00;
    // Fault status codes
    localparam logic [5:0] FSC_HW_UPDATE    = 6'h31;
    localparam logic [5:0] FSC_TLB_CONFLICT = 6'h30;
    // Write-back attribute encoding
    localparam logic [1:0] ATTR_WB = 2'h3;
    // Cache geometry, strap settle count and AXI response codes
    localparam int LINE_BYTES = 64;
    localparam int CACHE_WAYS = 4;
    localparam int IC_FILL_W  = 256;
    localparam int DC_L2_W    = 512;
    localparam int DC_RD_W    = 128;
    localparam int DC_RD_PATHS = 3;
    localparam int DC_WR_W    = 256;
    localparam int SYNC_SETTLE = 2;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MEM_NORMAL                 = 3'b000,
        MEM_STRICT_DEVICE_NO_EARLY = 3'b001,
        MEM_STRICT_DEVICE_EARLY    = 3'b010,
        MEM_REORDER_DEVICE_EARLY   = 3'b011,
        MEM_GATHER_REORDER_DEVICE  = 3'b100
    } mem_type_t;

    typedef enum logic [3:0] {
        SRC_WALK      = 4'h0,
        SRC_LD_NORMAL = 4'h1,
        SRC_LD_DEV_AQ = 4'h2,
        SRC_ATOMIC_LD = 4'h3,
        SRC_LD_DEVICE = 4'h4,
        SRC_STORE     = 4'h5,
        SRC_CACHE_MNT = 4'h6,
        SRC_TLB_INV   = 4'h7,
        SRC_IC_INV    = 4'h8
    } abort_src_t;

    typedef enum logic [1:0] {
        WALK_HYP = 2'b00,
        WALK_S1  = 2'b01,
        WALK_S2  = 2'b10
    } walk_regime_t;

    typedef enum logic [1:0] {
        INV_SETTLE = 2'b00,
        INV_RUN    = 2'b01,
        INV_DONE   = 2'b10
    } inv_state_t;

    typedef struct packed {
        logic [PA_W-1:0] pa;
        logic [2:0]      perm;
        logic            non_secure;
        logic            fault;
        logic [5:0]      fsc;
        logic            is_fetch;
        logic            is_write;
        logic            s1_on;
        logic            s2_on;
        logic            desc_s2;
        mem_type_t       mem_type;
        logic [1:0]      inner;
        logic [1:0]      outer;
        logic            af_clear;
        logic            dirty_bit_modifier_field;
        logic            contig_oob;
        logic [1:0]      page_hw_attribute_bits_s1;
        logic [1:0]      page_hw_attribute_bits_s2;
    } xlat_req_t;

    typedef struct packed {
        logic [PA_W-1:0] pa;
        logic [2:0]      perm;
        logic            non_secure;
        logic            abort;
        logic            abort_instr;
        logic [5:0]      fsc;
        mem_type_t       mem_type;
        logic            cacheable;
        logic            icache_lookup;
        logic            icache_alloc;
        logic            unified_alloc;
        logic            af_update;
        logic            dirty_update;
        logic [1:0]      page_hw_attribute_bits;
    } xlat_resp_t;
endpackage

// ### rtl/translation_attribute_resolver.sv
// Translation response, attribute resolution and L1 cache control
// How it works
// - Access flag updated only when stage enable set
// - Dirty update only with stage enable, modifier
// - Dirty management needs access flag management
// - Updates only in write-back, else abort 0x31
// - Response carries address, permissions, security, abort
// - Walk, normal/acquire loads, atomics abort synchronously
// - Synchronous abort records faulting address
// - Device loads, stores, maintenance abort asynchronously
// - Contiguous hint outside range never faults
// - TLB conflict abort never generated
// - Classify Normal or four device types
// - Cacheable only inner and outer write-back
// - MMU off, icache on: icache only
// - Two attribute bits, zero when disabled
// - Walk accesses use walk attribute registers
// - Stage two, else stage one, else zero
// - Stage merge applied per attribute bit
// - Cache sizes 32KB/64KB, 4-way, 64B lines
// - Data cache path widths fixed
// - Caches disabled, invalidated after reset release unless recovery strap high
// - Critical word first, separate enables, no lockdown
// - Icache off: no array access, non-cacheable
`timescale 1ns/1ns
module translation_attribute_resolver
    import xlat_attr_pkg::*;
#(
    parameter int ICACHE_KB = 32,
    parameter int DCACHE_KB = 32
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        debug_recovery_pin,
    input  wire logic        req_valid,
    input  wire xlat_req_t   req,
    output xlat_resp_t       resp,
    output logic             resp_valid,
    input  wire logic        walk_valid,
    input  wire walk_regime_t walk_regime,
    output logic [1:0]       walk_page_hw_attribute_bits,
    input  wire logic        ext_abort_valid,
    input  wire abort_src_t  ext_abort_src,
    input  wire logic [VA_W-1:0] ext_abort_addr,
    output logic             sync_abort,
    output logic             async_abort_pending,
    input  wire logic        miss_valid,
    input  wire logic [5:0]  miss_offset,
    output logic             fill_req,
    output logic [3:0]       fill_first_word,
    output logic             icache_on,
    output logic             dcache_on,
    output logic             inv_busy,
    output logic [7:0]       inv_index,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    // sets per cache at four ways of 64-byte lines
    // data cache path widths fixed in package
    localparam int IC_SETS = ICACHE_KB * 1024 / (LINE_BYTES * CACHE_WAYS);
    localparam int DC_SETS = DCACHE_KB * 1024 / (LINE_BYTES * CACHE_WAYS);
    localparam int MAX_SETS = (IC_SETS > DC_SETS) ? IC_SETS : DC_SETS;
    localparam logic [7:0] LAST_SET = 8'(MAX_SETS - 1);

    logic [CTRL_W-1:0] ctrl;
    logic [5:0]        walk_attr;
    logic [VA_W-1:0]   fault_addr;
    logic              async_pend;
    abort_src_t        async_src;
    logic              dbg_meta;
    logic              dbg_sync;
    logic              dbg_mode;
    logic [1:0]        settle;
    inv_state_t        inv_state;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_do;
    logic              sync_src;
    logic              async_clr;
    logic [31:0]       rd_word;
    logic              rd_hit;
    logic              wr_hit;
    xlat_resp_t        next_resp;
    logic [1:0]        merged_page_hw_attribute_bits;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Debug recovery strap synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dbg_meta <= 1'b0;
            dbg_sync <= 1'b0;
        end else if (ce) begin
            dbg_meta <= debug_recovery_pin;
            dbg_sync <= dbg_meta;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            inv_state <= INV_SETTLE;
            settle    <= 2'h0;
            inv_index <= 8'h00;
            dbg_mode  <= 1'b0;
        end else if (ce) begin
            unique case (inv_state)
                INV_SETTLE: begin
                    settle <= settle + 2'h1;
                    if (settle == 2'(SYNC_SETTLE)) begin
                        dbg_mode  <= dbg_sync;
                        inv_state <= dbg_sync ? INV_DONE : INV_RUN;
                    end
                end
                INV_RUN: begin
                    inv_index <= inv_index + 8'h01;
                    if (inv_index == LAST_SET) begin
                        inv_state <= INV_DONE;
                    end
                end
                INV_DONE: begin
                    inv_index <= 8'h00;
                end
                default: begin
                    inv_state <= INV_DONE;
                end
            endcase
        end
    end

    assign inv_busy = (inv_state != INV_DONE);
    // independent enables, held off while invalidating
    assign icache_on = ctrl[CTRL_IC_EN] & ~inv_busy;
    assign dcache_on = ctrl[CTRL_DC_EN] & ~inv_busy;

    // Per-bit stage merge of page attributes
    for (genvar i = 0; i < 2; i++) begin : g_page_hw_attribute_bits
        // each bit has its own enables
        logic s1_bit;
        logic s2_bit;
        assign s1_bit = req.s1_on & ctrl[CTRL_S1_PB + i];
        assign s2_bit = req.s2_on & ctrl[CTRL_S2_PB + i];
        // stage two wins, zero when neither
        assign merged_page_hw_attribute_bits[i] = s2_bit ? req.page_hw_attribute_bits_s2[i] :
                                s1_bit ? req.page_hw_attribute_bits_s1[i] : 1'b0;
    end

    // Resolve the translation outcome
    always_comb begin
        logic wb;
        logic af_en;
        logic ds_en;
        logic upd;
        logic dev;
        wb    = (req.inner == ATTR_WB) && (req.outer == ATTR_WB);
        dev   = (req.mem_type != MEM_NORMAL);
        af_en = req.desc_s2 ? ctrl[CTRL_S2_AF] : ctrl[CTRL_S1_AF];
        ds_en = (req.desc_s2 ? ctrl[CTRL_S2_DS] : ctrl[CTRL_S1_DS]) & af_en;
        next_resp = '0;
        next_resp.pa          = req.pa;
        next_resp.perm        = req.perm;
        next_resp.non_secure  = req.non_secure;
        next_resp.af_update   = req.af_clear & af_en;
        // dirty state via the modifier field
        next_resp.dirty_update = req.dirty_bit_modifier_field & req.is_write & ds_en;
        upd = next_resp.af_update | next_resp.dirty_update;
        // contiguous hint out of range adds no fault
        // only walk faults or update aborts exist
        next_resp.abort       = req.fault | (upd & ~wb);
        next_resp.abort_instr = req.is_fetch;
        next_resp.fsc = req.fault ? req.fsc :
                        (upd & ~wb) ? FSC_HW_UPDATE : 6'h00;
        if (upd & ~wb) begin
            next_resp.af_update    = 1'b0;
            next_resp.dirty_update = 1'b0;
        end
        next_resp.mem_type = (req.is_fetch & dev) ? MEM_NORMAL : req.mem_type;
        next_resp.cacheable = wb & ~dev;
        if (req.is_fetch) begin
            next_resp.icache_lookup = icache_on;
            if (!req.s1_on && !req.s2_on && icache_on) begin
                next_resp.icache_alloc  = 1'b1;
                next_resp.unified_alloc = 1'b0;
            end else begin
                next_resp.cacheable     = next_resp.cacheable & icache_on;
                next_resp.icache_alloc  = next_resp.cacheable;
                next_resp.unified_alloc = next_resp.cacheable & dcache_on;
            end
        end else begin
            next_resp.cacheable     = next_resp.cacheable & dcache_on;
            next_resp.unified_alloc = next_resp.cacheable;
        end
        next_resp.page_hw_attribute_bits = merged_page_hw_attribute_bits;
    end

    // Registered translation response
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            resp       <= '0;
            resp_valid <= 1'b0;
        end else if (ce) begin
            resp_valid <= req_valid;
            if (req_valid) begin
                resp <= next_resp;
            end
        end
    end

    // walk accesses take attribute bits from registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            walk_page_hw_attribute_bits <= 2'h0;
        end else if (ce && walk_valid) begin
            unique case (walk_regime)
                WALK_HYP: walk_page_hw_attribute_bits <= walk_attr[1:0];
                WALK_S1:  walk_page_hw_attribute_bits <= walk_attr[3:2];
                WALK_S2:  walk_page_hw_attribute_bits <= walk_attr[5:4];
                default:  walk_page_hw_attribute_bits <= 2'h0;
            endcase
        end
    end

    always_comb begin
        sync_src = (ext_abort_src == SRC_WALK) || (ext_abort_src == SRC_LD_NORMAL)
                || (ext_abort_src == SRC_LD_DEV_AQ) || (ext_abort_src == SRC_ATOMIC_LD);
    end

    // Synchronous abort pulse and fault address capture
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_abort <= 1'b0;
            fault_addr <= '0;
        end else if (ce) begin
            sync_abort <= ext_abort_valid & sync_src;
            if (ext_abort_valid && sync_src) begin
                fault_addr <= ext_abort_addr;
            end
        end
    end

    // asynchronous abort sticky flag, set beats clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            async_pend <= 1'b0;
            async_src  <= SRC_WALK;
        end else if (ce) begin
            if (ext_abort_valid && !sync_src) begin
                async_pend <= 1'b1;
                async_src  <= ext_abort_src;
            end else if (async_clr) begin
                async_pend <= 1'b0;
            end
        end
    end
    assign async_abort_pending = async_pend;

    // linefill starts at the critical word
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_req        <= 1'b0;
            fill_first_word <= 4'h0;
        end else if (ce) begin
            fill_req <= miss_valid;
            if (miss_valid) begin
                fill_first_word <= miss_offset[5:2];
            end
        end
    end

    // Write channel capture
    assign awready = ~aw_got & ~bvalid;
    assign wready  = ~w_got & ~bvalid;
    assign wr_do   = aw_got & w_got & ~bvalid;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= AXI_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_got  <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_got  <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_do) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Write address decode
    always_comb begin
        wr_hit = (aw_addr == OFS_CTRL) || (aw_addr == OFS_WALK_ATTR)
              || (aw_addr == OFS_ASYNC) || (aw_addr == OFS_STATUS)
              || (aw_addr == OFS_FAULT_LO) || (aw_addr == OFS_FAULT_HI)
              || (aw_addr == OFS_GEOMETRY);
        async_clr = wr_do && (aw_addr == OFS_ASYNC) && w_strb[0] && w_data[0];
    end

    // Software-written control registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl      <= CTRL_RESET;
            walk_attr <= WALK_RESET;
        end else if (ce && wr_do) begin
            if (aw_addr == OFS_CTRL) begin
                ctrl <= CTRL_W'(lane_merge(32'(ctrl), w_data, w_strb));
            end
            if (aw_addr == OFS_WALK_ATTR) begin
                walk_attr <= 6'(lane_merge(32'(walk_attr), w_data, w_strb));
            end
        end
    end

    // Read decode
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0;
        unique case (araddr)
            OFS_CTRL:      rd_word = 32'(ctrl);
            OFS_WALK_ATTR: rd_word = 32'(walk_attr);
            OFS_STATUS:    rd_word = {28'h0, dcache_on, icache_on, dbg_mode, inv_busy};
            OFS_FAULT_LO:  rd_word = fault_addr[31:0];
            OFS_FAULT_HI:  rd_word = 32'(fault_addr[VA_W-1:32]);
            OFS_ASYNC:     rd_word = {24'h0, async_src, 3'h0, async_pend};
            OFS_GEOMETRY:  rd_word = {16'h0, 8'(DCACHE_KB), 8'(ICACHE_KB)};
            default: begin
                rd_hit  = 1'b0;
                rd_word = 32'h0;
            end
        endcase
    end

    // Read channel
    assign arready = ~rvalid;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= AXI_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Checks
    update_abort_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && req_valid && (req.af_clear && !req.desc_s2 && ctrl[CTRL_S1_AF])
        && !req.fault && (req.inner != ATTR_WB || req.outer != ATTR_WB)
        |=> resp.abort && resp.fsc == FSC_HW_UPDATE)
        else $error("update outside write-back did not abort");
    dirty_needs_af_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        resp_valid && resp.dirty_update |-> $past(ctrl[CTRL_S1_AF] | ctrl[CTRL_S2_AF]))
        else $error("dirty update without access flag management");
    resp_timing_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && req_valid |=> resp_valid && resp.pa == $past(req.pa))
        else $error("response missing or wrong address");
    sync_abort_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && ext_abort_valid && ext_abort_src == SRC_LD_NORMAL
        |=> sync_abort && fault_addr == $past(ext_abort_addr))
        else $error("synchronous abort not recorded");
    async_abort_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && ext_abort_valid && ext_abort_src == SRC_STORE |=> async_pend && !sync_abort)
        else $error("store abort not held asynchronous");
    no_conflict_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        resp_valid |-> resp.fsc != FSC_TLB_CONFLICT || $past(req.fsc) == FSC_TLB_CONFLICT)
        else $error("conflict abort generated");
    cacheable_wb_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && req_valid && req.outer != ATTR_WB && !req.is_fetch |=> !resp.cacheable)
        else $error("non write-back page marked cacheable");
    page_hw_attribute_bits_merge_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && req_valid && !ctrl[CTRL_S1_PB] && !ctrl[CTRL_S2_PB] |=> resp.page_hw_attribute_bits[0] == 1'b0)
        else $error("disabled attribute bit not zero");
    icache_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && req_valid && req.is_fetch && !icache_on |=> !resp.icache_lookup && !resp.cacheable)
        else $error("fetch used disabled instruction cache");
    reset_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        inv_busy |-> !icache_on && !dcache_on)
        else $error("cache enabled during invalidation");
endmodule

// ### sim/core_pipe_model.sv
// Core pipeline model that presents translation results
`timescale 1ns/1ns
module core_pipe_model
    import xlat_attr_pkg::*;
(
    input  wire logic core_clk,
    output logic      req_valid,
    output xlat_req_t req
);
    // Idle until the first request
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // One-cycle request; payload scrambled once released
    task automatic issue(input xlat_req_t q);
        req       <= q;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req       <= xlat_req_t'(~q);
    endtask
endmodule

// ### sim/tb_translation_attribute_resolver.sv
// Self-checking bench for the translation attribute resolver
`timescale 1ns/1ns
module tb_translation_attribute_resolver
    import xlat_attr_pkg::*;
;
    logic         core_clk = 1'b0, arst_n = 1'b0, walk_valid = 1'b0, miss_valid = 1'b0;
    logic         ext_abort_valid = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic         arvalid = 1'b0, rready = 1'b0, dbg_pin = 1'b0;
    walk_regime_t walk_regime = WALK_HYP;
    abort_src_t   ext_abort_src = SRC_WALK;
    logic [47:0]  ext_abort_addr = '0;
    logic [5:0]   miss_offset = '0;
    logic [7:0]   awaddr = '0, araddr = '0, inv_index;
    logic [31:0]  wdata = '0, rdata;
    logic         req_valid, resp_valid, sync_abort, async_abort_pending, awready, wready;
    logic         bvalid, arready, rvalid, inv_busy, fill_req, icache_on, dcache_on;
    logic [1:0]   walk_page_hw_attribute_bits, bresp, rresp;
    logic [3:0]   fill_first_word;
    xlat_req_t    req, r0, r;
    xlat_resp_t   resp;
    int           fails = 0, compares = 0, busy = 0;
    localparam int SETS = 32 * 1024 / (LINE_BYTES * CACHE_WAYS);

    translation_attribute_resolver dut (.ce(1'b1), .debug_recovery_pin(dbg_pin), .wstrb(4'hf),
        .*);
    core_pipe_model pm (.core_clk(core_clk), .req_valid(req_valid), .req(req));

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test;
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Fetch routing: instruction abort, lookup, icache and unified allocation
    task automatic fchk(input logic [3:0] e);
        chk({resp.abort_instr, resp.icache_lookup, resp.icache_alloc, resp.unified_alloc}, e);
    endtask
    // Count falling edges until invalidation ends
    task automatic wait_idle;
        busy = 0;
        do begin
            @(negedge core_clk);
            busy++;
        end while (inv_busy !== 1'b0 && busy < 400);
    endtask
    // Register write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        chk(bvalid, 1'b1);
        bready <= 1'b0;
        chk(bresp, AXI_OKAY);
    endtask
    // Register read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n = 0;
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        chk(rvalid, 1'b1);
        rready <= 1'b0;
        chk(rresp, e);
        if (e == AXI_OKAY) chk(rdata, d);
    endtask
    // Translation; e is abort, code, cacheable, flag, dirty, attribute bits
    task automatic tx(input xlat_req_t q, input logic [11:0] e);
        @(posedge core_clk);
        pm.issue(q);
        @(negedge core_clk);
        chk({resp_valid, resp.pa, resp.perm, resp.non_secure, resp.mem_type},
            {1'b1, q.pa, q.perm, q.non_secure, q.mem_type});
        chk({resp.abort, resp.fsc, resp.cacheable, resp.af_update, resp.dirty_update, resp.page_hw_attribute_bits}, e);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        chk(inv_busy, 1'b1);
        arst_n <= 1'b1;
        wait_idle();
        chk(busy, SYNC_SETTLE + 2 + SETS);
        chk(inv_index, SETS);
        rd(OFS_STATUS, 32'h0, AXI_OKAY);
        rd(OFS_GEOMETRY, 32'h2020, AXI_OKAY);
        rd(8'h40, 32'h0, AXI_SLVERR);
        wr(OFS_CTRL, 32'h10);
        rd(OFS_STATUS, 32'h4, AXI_OKAY);
        wr(OFS_CTRL, 32'h273);
        r0 = '{pa: 48'h8765_4000, perm: 3'h5, non_secure: 1'b1, is_write: 1'b1, s1_on: 1'b1,
               s2_on: 1'b1, mem_type: MEM_NORMAL, inner: ATTR_WB, outer: ATTR_WB,
               af_clear: 1'b1, dirty_bit_modifier_field: 1'b1, page_hw_attribute_bits_s1: 2'h3, default: '0};
        tx(r0, 12'h01d);
        r = r0;
        r.outer = 2'h0;
        tx(r, 12'he21);
        r = r0;
        r.desc_s2 = 1'b1;
        tx(r, 12'h011);
        r = r0;
        r.dirty_bit_modifier_field = 1'b0;
        tx(r, 12'h019);
        r = r0;
        r.contig_oob = 1'b1;
        tx(r, 12'h01d);
        r.inner = 2'h0;
        r.outer = 2'h0;
        r.af_clear = 1'b0;
        r.dirty_bit_modifier_field = 1'b0;
        for (int m = 1; m < 5; m++) begin
            r.mem_type = mem_type_t'(m);
            tx(r, 12'h001);
        end
        // Fetches with translation off, icache on then off, then a translated write
        r = r0;
        r.is_fetch = 1'b1;
        r.is_write = 1'b0;
        r.af_clear = 1'b0;
        r.s1_on = 1'b0;
        r.s2_on = 1'b0;
        tx(r, 12'h010);
        fchk(4'he);
        wr(OFS_CTRL, 32'h262);
        chk({icache_on, dcache_on}, 2'b01);
        rd(OFS_STATUS, 32'h8, AXI_OKAY);
        tx(r, 12'h000);
        fchk(4'h8);
        tx(r0, 12'h011);
        fchk(4'h1);
        // Every abort source, one pulse each
        for (int s = 0; s < 9; s++) begin
            @(posedge core_clk);
            ext_abort_src <= abort_src_t'(s);
            ext_abort_addr <= 48'h1234_5600 + 48'(s);
            ext_abort_valid <= 1'b1;
            @(posedge core_clk);
            ext_abort_valid <= 1'b0;
            @(negedge core_clk);
            chk(sync_abort, s < 4);
        end
        chk(async_abort_pending, 1'b1);
        rd(OFS_ASYNC, 32'h81, AXI_OKAY);
        wr(OFS_ASYNC, 32'h1);
        rd(OFS_ASYNC, 32'h80, AXI_OKAY);
        rd(OFS_FAULT_LO, 32'h1234_5603, AXI_OKAY);
        wr(OFS_WALK_ATTR, 32'h24);
        for (int w = 0; w < 3; w++) begin
            @(posedge core_clk);
            walk_regime <= walk_regime_t'(w);
            walk_valid <= 1'b1;
            @(posedge core_clk);
            walk_valid <= 1'b0;
            @(negedge core_clk);
            chk(walk_page_hw_attribute_bits, w);
        end
        @(posedge core_clk);
        miss_offset <= 6'h2c;
        miss_valid <= 1'b1;
        @(posedge core_clk);
        miss_valid <= 1'b0;
        @(negedge core_clk);
        chk({fill_req, fill_first_word}, 5'h1b);
        // Second reset with the recovery strap high skips invalidation
        dbg_pin <= 1'b1;
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        wait_idle();
        chk(busy, SYNC_SETTLE + 2);
        rd(OFS_STATUS, 32'h2, AXI_OKAY);
        finish_test();
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule
